// [hdl/fpl_map.vh]
// Constants for the front panel memory loader sequencer.
// Assumes a single 40 MHz system clock and synchronous operator pulses.
`ifndef FPL_MAP_VH
`define FPL_MAP_VH

`define FPL_ADDR_W 16
`define FPL_DATA_W 8
`define FPL_MEM_WORDS 256
`define FPL_MEM_AW 8
`define FPL_RESET_ADDR 16'h0000
`define FPL_LAMP_RESET 8'h00

`endif

// [hdl/fpl_front_panel.v]
// Front panel sequencer: operator actions become memory and run operations.
// Assumes each action input is a one-cycle pulse, already debounced and
// synchronous; switch inputs are level and read up = 1.
// A new action during a pending lamp refresh restarts that refresh.
// Writes made while protect is up are lost, not deferred.
`timescale 1ns/1ps
`include "fpl_map.vh"

module fpl_front_panel #(
    parameter MEM_WORDS = `FPL_MEM_WORDS,
    parameter MEM_AW = `FPL_MEM_AW
) (
    input wire clock_i,
    input wire nrst_i,
    input wire [`FPL_ADDR_W-1:0] addr_sw_i,
    input wire [`FPL_DATA_W-1:0] data_sw_i,
    input wire reset_act_i,
    input wire deposit_i,
    input wire store_following_i,
    input wire examine_i,
    input wire show_following_i,
    input wire run_i,
    input wire stop_i,
    input wire protect_i,
    input wire cpu_step_i,
    input wire [`FPL_ADDR_W-1:0] cpu_pc_i,
    input wire cpu_we_i,
    input wire [`FPL_ADDR_W-1:0] cpu_addr_i,
    input wire [`FPL_DATA_W-1:0] cpu_wdata_i,
    output reg [`FPL_ADDR_W-1:0] pc_o,
    output reg run_o,
    output reg [`FPL_DATA_W-1:0] data_lamps_o,
    output reg [`FPL_ADDR_W-1:0] addr_lamps_o,
    output reg protect_lamp_o,
    output reg [`FPL_DATA_W-1:0] cpu_rdata_o
);

    // Panel states, binary coded
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_READ = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    // Decoded panel action after priority
    localparam [2:0] ACT_NONE = 3'h0;
    localparam [2:0] ACT_ZERO = 3'h1;
    localparam [2:0] ACT_EXAM = 3'h2;
    localparam [2:0] ACT_SHOW_FOL = 3'h3;
    localparam [2:0] ACT_DEP = 3'h4;
    localparam [2:0] ACT_STORE_FOL = 3'h5;

    reg [`FPL_DATA_W-1:0] mem_q [0:MEM_WORDS-1];
    reg [`FPL_ADDR_W-1:0] pc_d;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [2:0] act;
    reg wr_en;
    reg [`FPL_ADDR_W-1:0] wr_addr;
    reg [`FPL_DATA_W-1:0] wr_data;
    reg rd_show;
    reg run_d;
    wire panel_ok;
    wire [`FPL_ADDR_W-1:0] pc_inc;

    // Memory index from a panel or processor address; upper bits wrap
    function [MEM_AW-1:0] fpl_idx;
        input [`FPL_ADDR_W-1:0] a;
        begin
            fpl_idx = a[MEM_AW-1:0];
        end
    endfunction

    // Next sequential address; the carry out of the top bit is dropped
    function [`FPL_ADDR_W-1:0] fpl_next;
        input [`FPL_ADDR_W-1:0] a;
        reg [`FPL_ADDR_W:0] sum;
        begin
            sum = {1'b0, a} + {{`FPL_ADDR_W{1'b0}}, 1'b1};
            fpl_next = sum[`FPL_ADDR_W-1:0];
        end
    endfunction

    assign panel_ok = ~run_o;
    assign pc_inc = fpl_next(pc_o);

    // Priority among simultaneous actions: zero, examine,
    // show-following, deposit, store-following
    always @* begin
        act = ACT_NONE;
        if (reset_act_i) begin
            act = ACT_ZERO;
        end else if (examine_i) begin
            act = ACT_EXAM;
        end else if (show_following_i) begin
            act = ACT_SHOW_FOL;
        end else if (deposit_i) begin
            act = ACT_DEP;
        end else if (store_following_i) begin
            act = ACT_STORE_FOL;
        end
    end

    // Panel sequencer; panel actions are ignored while running
    always @* begin
        pc_d = pc_o;
        state_d = state_q;
        rd_show = 1'b0;
        if (run_o) begin
            // While running the counter belongs to the processor
            state_d = ST_RUN;
            if (cpu_step_i) begin
                pc_d = cpu_pc_i;
            end
        end else begin
            case (act)
                ACT_ZERO: begin
                    pc_d = `FPL_RESET_ADDR;
                    state_d = ST_READ;
                end
                ACT_EXAM: begin
                    pc_d = addr_sw_i;
                    state_d = ST_READ;
                end
                ACT_SHOW_FOL: begin
                    pc_d = pc_inc;
                    state_d = ST_READ;
                end
                ACT_DEP: begin
                    pc_d = pc_o;
                    state_d = ST_READ;
                end
                ACT_STORE_FOL: begin
                    pc_d = pc_inc;
                    state_d = ST_READ;
                end
                default: begin
                    case (state_q)
                        ST_READ: begin
                            // refresh lamps once the address settles
                            rd_show = 1'b1;
                            state_d = ST_IDLE;
                        end
                        ST_RUN: begin
                            // show the stop address after a halt
                            state_d = ST_READ;
                        end
                        default: begin
                            state_d = ST_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    // Write port shared by panel deposits and processor stores
    always @* begin
        wr_en = 1'b0;
        wr_addr = pc_o;
        wr_data = data_sw_i;
        if (run_o) begin
            // Processor owns the port while running
            wr_en = cpu_we_i;
            wr_addr = cpu_addr_i;
            wr_data = cpu_wdata_i;
        end else if (act == ACT_DEP) begin
            wr_en = 1'b1;
        end else if (act == ACT_STORE_FOL) begin
            wr_en = 1'b1;
            wr_addr = pc_inc;
        end
        // protect blocks every write, processor ones included
        if (protect_i) begin
            wr_en = 1'b0;
        end
    end

    always @* begin
        run_d = run_o;
        if (stop_i) begin
            run_d = 1'b0;
        end else if (run_i && panel_ok) begin
            run_d = 1'b1;
        end
    end

    // memory of MEM_WORDS bytes; uninitialised as after power-up
    always @(posedge clock_i) begin
        if (wr_en) begin
            mem_q[fpl_idx(wr_addr)] <= wr_data;
        end
        // Processor read port: one cycle behind its address
        cpu_rdata_o <= mem_q[fpl_idx(cpu_addr_i)];
    end

    always @(posedge clock_i) begin
        if (!nrst_i) begin
            pc_o <= `FPL_RESET_ADDR;
            run_o <= 1'b0;
            state_q <= ST_IDLE;
            data_lamps_o <= `FPL_LAMP_RESET;
            addr_lamps_o <= `FPL_RESET_ADDR;
            protect_lamp_o <= 1'b0;
        end else begin
            pc_o <= pc_d;
            state_q <= state_d;
            run_o <= run_d;
            // Address lamps follow the counter on the same edge
            addr_lamps_o <= pc_d;
            protect_lamp_o <= protect_i;
            // lamps load only on a refresh
            if (rd_show) begin
                data_lamps_o <= mem_q[fpl_idx(pc_o)];
            end
        end
    end

endmodule // fpl_front_panel

// [dv/fpl_cpu_model.sv]
// Processor stand-in: steps its program counter while run is granted.
`timescale 1ns/1ps
module fpl_cpu_model (
    input wire clock_i,
    input wire run_i,
    input wire [15:0] pc_i,
    output reg step_o = 1'b0,
    output reg [15:0] pc_o = 16'h0000
);
    // Start from the panel address so execution resumes where it stopped
    always @(posedge clock_i) begin
        step_o <= run_i;
        pc_o <= run_i ? pc_o + 16'h0001 : pc_i;
    end
endmodule // fpl_cpu_model

// [dv/fpl_chk_asserts.sv]
// Port checker for the panel sequencer, bound onto its top module.
`timescale 1ns/1ps
module fpl_chk (
    input wire clock_i,
    input wire nrst_i,
    input wire reset_act_i,
    input wire deposit_i,
    input wire store_following_i,
    input wire examine_i,
    input wire show_following_i,
    input wire run_i,
    input wire stop_i,
    input wire protect_i,
    input wire run_o,
    input wire protect_lamp_o,
    input wire [15:0] addr_sw_i,
    input wire [15:0] pc_o,
    input wire [15:0] addr_lamps_o,
    input wire [7:0] data_lamps_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire ok = !run_o && !reset_act_i;
    wire hi = ok && !examine_i && !show_following_i;
    chk_pc_zero: assert property (reset_act_i && !run_o |=> pc_o == 0)
        else $error("pc not cleared");
    chk_dep_hold: assert property (hi && deposit_i |=> $stable(pc_o))
        else $error("deposit moved pc");
    chk_store_inc: assert property (hi && !deposit_i && store_following_i
        |=> pc_o == $past(pc_o) + 16'h1) else $error("store step");
    chk_show_inc: assert property (ok && !examine_i && show_following_i
        |=> pc_o == $past(pc_o) + 16'h1) else $error("show step");
    chk_exam_addr: assert property (ok && examine_i
        |=> pc_o == $past(addr_sw_i)) else $error("examine address");
    chk_run_go: assert property (run_i && !stop_i |=> run_o)
        else $error("run not granted");
    chk_stop_halt: assert property (stop_i |=> !run_o)
        else $error("stop ignored");
    chk_prot_lamp: assert property (protect_lamp_o == $past(protect_i))
        else $error("protect lamp");
    chk_addr_lamps: assert property (addr_lamps_o == pc_o)
        else $error("address lamps off counter");
    // Halted and no panel action in this cycle
    sequence s_panel_quiet;
        !run_o && !reset_act_i && !deposit_i && !store_following_i
            && !examine_i && !show_following_i;
    endsequence
    // Any pending refresh has landed after three quiet cycles
    chk_lamp_hold: assert property (s_panel_quiet [*3]
        |=> $stable(data_lamps_o)) else $error("lamps changed while quiet");
endmodule // fpl_chk
bind fpl_front_panel fpl_chk u_chk (.clock_i, .nrst_i, .reset_act_i,
    .deposit_i, .store_following_i, .examine_i, .show_following_i, .run_i,
    .stop_i, .protect_i, .run_o, .protect_lamp_o, .addr_sw_i, .pc_o,
    .addr_lamps_o, .data_lamps_o);

// [dv/front_panel_memory_loader_bench.sv]
// Bench for the panel sequencer: load, protect, run and stop.
`timescale 1ns/1ps
module front_panel_memory_loader_bench;
    reg clock_i = 0, nrst_i = 0, protect_i = 0;
    reg [6:0] a = 7'h00;
    reg [7:0] sw = 8'h00;
    wire step, run_o, plamp;
    wire [15:0] pc_o, cpc;
    wire [7:0] lamps;
    wire [15:0] alamps;
    wire [7:0] crd;
    reg cwe = 1'b0;
    reg [7:0] cwd = 8'h00;
    reg [15:0] ca = 16'h0000;
    int errors = 0, checked = 0;
    always #12.5 clock_i = ~clock_i;
    fpl_cpu_model cpu (.clock_i, .run_i(run_o), .pc_i(pc_o), .step_o(step),
        .pc_o(cpc));
    fpl_front_panel dut (.clock_i, .nrst_i, .addr_sw_i({8'h00, sw}),
        .data_sw_i(sw), .reset_act_i(a[0]), .deposit_i(a[1]),
        .store_following_i(a[2]), .examine_i(a[3]), .show_following_i(a[4]),
        .run_i(a[5]), .stop_i(a[6]), .protect_i, .cpu_step_i(step),
        .cpu_pc_i(cpc), .cpu_we_i(cwe), .cpu_addr_i(ca),
        .cpu_wdata_i(cwd), .pc_o, .run_o, .data_lamps_o(lamps),
        .addr_lamps_o(alamps), .protect_lamp_o(plamp), .cpu_rdata_o(crd));
    task chk(input [15:0] s, input [15:0] e); begin
        checked++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    end endtask
    // Pulse one action, then wait until the lamps have refreshed
    task go(input int b, input [7:0] d); begin
        @(negedge clock_i); sw = d; a[b] = 1'b1;
        @(negedge clock_i); a = 7'h00;
        repeat (2) @(negedge clock_i);
    end endtask
    task t_load; begin
        go(0, 8'hA5); chk(pc_o, 16'h0000); // cleared
        go(1, 8'hA5); chk(lamps, 8'hA5); // written
        go(2, 8'h3C); chk(pc_o, 16'h0001); // advanced
        go(1, 8'h5A); chk(pc_o, 16'h0001); // held
        go(3, 8'hFF); chk(pc_o, 16'h00FF); // selected
        chk(alamps, 16'h00FF); // address lamps
        go(1, 8'h77); go(4, 8'h00); chk(pc_o, 16'h0100); // advanced
        chk(alamps, 16'h0100); // address lamps
        chk(lamps, 8'hA5); // wraps
        go(3, 8'h01); chk(lamps, 8'h5A); // shown
    end endtask
    task t_prot; begin
        protect_i = 1'b1; go(1, 8'hEE); chk(plamp, 1'b1); // lamp
        chk(lamps, 8'h5A); // unchanged
        protect_i = 1'b0;
    end endtask
    // Reset pulled while running: run, counter and lamp outputs go idle, memory is kept
    task t_rst; begin
        go(5, 8'h00);
        @(negedge clock_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(run_o, 1'b0); // halted by reset
        chk(pc_o, 16'h0000); // counter zero
        chk(alamps, 16'h0000); // address lamps zero
        chk(lamps, 8'h00); // lamps dark
        nrst_i = 1'b1;
        go(3, 8'h01); chk(lamps, 8'h5A); // memory kept
    end endtask
    // Processor store at 0x10 while running; p raises protect with it
    task cpu_wr(input [7:0] d, input p); begin
        @(negedge clock_i);
        ca = 16'h0010;
        cwd = d;
        cwe = 1'b1;
        protect_i = p;
        @(negedge clock_i);
        cwe = 1'b0;
        protect_i = 1'b0;
        @(negedge clock_i);
    end endtask
    task t_run; begin
        go(0, 8'h00); go(5, 8'h00); chk(run_o, 1'b1); // running
        cpu_wr(8'hC3, 1'b0); chk(crd, 8'hC3); // processor store
        cpu_wr(8'h3C, 1'b1); chk(crd, 8'hC3); // store blocked
        go(6, 8'h00); chk(run_o, 1'b0); // halted
        go(3, 8'hFF); chk(lamps, 8'h77); // inspect
        go(3, 8'h10); chk(lamps, 8'hC3); // stored byte
    end endtask
    task conclude; begin
        if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    end endtask
    initial begin #200000; errors++; conclude; end
    initial begin
        repeat (8) @(negedge clock_i);
        nrst_i = 1'b1;
        t_load; t_prot; t_run; t_rst; conclude;
    end
endmodule // front_panel_memory_loader_bench
